// ### src/fepr_regs.svh
// register offsets, field positions and load constants for the protection block
// Overview of operation
// - normal mode pflash writes only enlarge protection
// - special mode pflash bits written freely, except size while disable clear
// - reset loads pflash config from 0xFF_FE0C
// - pflash load fault gives full protection
// - protected pflash attempt sets violation flag
// - pflash block erase refused if any protected
// - op enable and high disable select function
// - high size field gives 2, 4, 8 KB
// - high size written only while disable set
// - normal eeprom writes only add protection
// - eeprom disable set ignores size field
// - special mode eeprom fields written freely
// - reset loads eeprom config from 0xFF_FE0D
// - eeprom load fault gives full protection
// - protected eeprom attempt sets same flag
// - eeprom block erase refused if protected
// - eeprom disable bit: 0 protect, 1 open
// - eeprom size gives 32 to 128 bytes
// - flag blocks launch, write one clears
`ifndef FEPR_REGS_SVH
`define FEPR_REGS_SVH
`define FEPR_STATUS_OFS 12'h004
`define FEPR_PF_OFS 12'h008
`define FEPR_EE_OFS 12'h00C
`define FEPR_VIOL_BIT 4
`define FEPR_PF_OPEN_BIT 7
`define FEPR_PF_HDIS_BIT 5
`define FEPR_EE_DIS_BIT 7
`define FEPR_EE_MASK 8'h83
`define FEPR_PF_CFG_ADDR 24'hFFFE0C
`define FEPR_EE_CFG_ADDR 24'hFFFE0D
`define FEPR_PF_FAULT_VAL 8'h7F
`define FEPR_EE_FAULT_VAL 8'h03
`define FEPR_PF_RST_VAL 8'h7F
`define FEPR_EE_RST_VAL 8'h03
`define FEPR_HI_BASE_2K 24'hFFF800
`define FEPR_HI_BASE_4K 24'hFFF000
`define FEPR_HI_BASE_8K 24'hFFE000
`define FEPR_EE_BASE 24'h100000
`define FEPR_EE_STEP 24'h000020
`endif

// ### src/fepr_pkg.sv
// types shared by the protection block
package fepr_pkg;
    typedef enum logic [1:0] {
        FEPR_LD_PF = 2'b00,
        FEPR_LD_EE = 2'b01,
        FEPR_READY = 2'b11
    } fepr_state_t;
    typedef logic [23:0] fepr_addr_t;
endpackage : fepr_pkg

// ### src/fepr_top.sv
// flash and eeprom protection registers, reset load and address check
`timescale 1ns/1ns
`default_nettype none
`include "fepr_regs.svh"
module fepr_top
    import fepr_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic special_mode_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [ADDR_W-1:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    output logic cfg_rd_req_out,
    output logic [23:0] cfg_rd_addr_out,
    input wire logic cfg_rd_valid_in,
    input wire logic [7:0] cfg_rd_data_in,
    input wire logic cfg_rd_dbl_fault_in,
    output logic load_done_out,
    input wire logic chk_valid_in,
    input wire logic [23:0] chk_addr_in,
    input wire logic chk_eeprom_in,
    input wire logic chk_blk_erase_in,
    output logic chk_allowed_out,
    output logic cmd_launch_ok_out
);

    fepr_state_t state_q, state_d;
    logic [7:0] pf_q, pf_d;
    logic [7:0] ee_q, ee_d;
    logic viol_q, viol_d;
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;
    logic ack_q, ack_d;
    logic acc;
    logic wr_st, wr_pf, wr_ee;
    logic pf_prot, ee_prot, refused;
    logic [7:0] pf_full, pf_alt1, pf_alt2, pf_keep, pf_wr;
    logic [1:0] pf_wsz;
    logic [7:0] ee_wr;

    // effective high range size: codes 10 and 11 both mean 8 KB
    function automatic logic [1:0] pf_eff(input logic [1:0] s);
        pf_eff = s[1] ? 2'h2 : s;
    endfunction : pf_eff

    // lowest address of the high range for a size code
    function automatic fepr_addr_t hi_base(input logic [1:0] s);
        fepr_addr_t b;
        case (s)
            2'b00: b = `FEPR_HI_BASE_2K;
            2'b01: b = `FEPR_HI_BASE_4K;
            default: b = `FEPR_HI_BASE_8K;
        endcase
        hi_base = b;
    endfunction : hi_base

    // true when the protected set of n contains that of o
    function automatic logic pf_covers(input logic [7:0] n, input logic [7:0] o);
        logic [1:0] ns;
        logic [1:0] os;
        logic [1:0] of;
        logic r;
        ns = pf_eff(n[4:3]);
        os = pf_eff(o[4:3]);
        of = {o[`FEPR_PF_OPEN_BIT], o[`FEPR_PF_HDIS_BIT]};
        case ({n[`FEPR_PF_OPEN_BIT], n[`FEPR_PF_HDIS_BIT]})
            2'b01: r = 1'b1;
            2'b11: r = (of == 2'b11);
            2'b10: r = (of == 2'b11) || ((of == 2'b10) && (ns >= os));
            2'b00: r = (of == 2'b11) || ((of == 2'b00) && (ns <= os));
            default: r = 1'b0;
        endcase
        pf_covers = r;
    endfunction : pf_covers

    // address decode, shared by read and write paths
    function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
        logic [1:0] s;
        case (a)
            `FEPR_STATUS_OFS: s = 2'h1;
            `FEPR_PF_OFS: s = 2'h2;
            `FEPR_EE_OFS: s = 2'h3;
            default: s = 2'h0;
        endcase
        reg_sel = s;
    endfunction : reg_sel

    // apb access phase; one wait state so registered read data stands with pready
    assign acc = psel_in && penable_in;
    assign wr_st = acc && ack_q && pwrite_in && (reg_sel(paddr_in) == 2'h1);
    assign wr_pf = acc && ack_q && pwrite_in && (reg_sel(paddr_in) == 2'h2);
    assign wr_ee = acc && ack_q && pwrite_in && (reg_sel(paddr_in) == 2'h3);
    assign pready_out = ack_q;
    assign prdata_out = rdata_q;
    assign pslverr_out = err_q;

    // protection decode for the address offered by the command controller
    always_comb begin
        case ({pf_q[`FEPR_PF_OPEN_BIT], pf_q[`FEPR_PF_HDIS_BIT]})
            2'b11: pf_prot = 1'b0;
            2'b10: pf_prot = (chk_addr_in >= hi_base(pf_q[4:3]));
            2'b01: pf_prot = 1'b1;
            default: pf_prot = (chk_addr_in < hi_base(pf_q[4:3]));
        endcase
        // any protected sector blocks the single pflash block erase
        if (chk_blk_erase_in) begin
            pf_prot = ({pf_q[`FEPR_PF_OPEN_BIT], pf_q[`FEPR_PF_HDIS_BIT]} != 2'b11);
        end
        // the size field has no say while the disable bit is set
        if (ee_q[`FEPR_EE_DIS_BIT]) begin
            ee_prot = 1'b0;
        end else if (chk_blk_erase_in) begin
            ee_prot = 1'b1;
        end else begin
            ee_prot = (chk_addr_in >= `FEPR_EE_BASE) && (chk_addr_in < (`FEPR_EE_BASE
                + (`FEPR_EE_STEP * {22'h0, ee_q[1:0]}) + `FEPR_EE_STEP));
        end
        refused = chk_eeprom_in ? ee_prot : pf_prot;
    end

    assign chk_allowed_out = chk_valid_in && !refused;
    assign cmd_launch_ok_out = !viol_q;

    // candidate values for a pflash write, widest first
    always_comb begin
        pf_wsz = pf_q[`FEPR_PF_HDIS_BIT] ? pwdata_in[4:3] : pf_q[4:3];
        pf_full = {pwdata_in[7:5], pf_wsz, pwdata_in[2:0]};
        pf_alt1 = {pwdata_in[7:5], pf_q[4:3], pwdata_in[2:0]};
        pf_alt2 = {pf_q[7], pwdata_in[6], pf_q[5], pf_wsz, pwdata_in[2:0]};
        pf_keep = {pf_q[7], pwdata_in[6], pf_q[5:3], pwdata_in[2:0]};
        // reserved nv bits pass as written; leaving them erased is software's job
        if (special_mode_in) begin
            pf_wr = pf_full;
        end else if (pf_covers(pf_full, pf_q)) begin
            pf_wr = pf_full;
        end else if (pf_covers(pf_alt1, pf_q)) begin
            pf_wr = pf_alt1;
        end else if (pf_covers(pf_alt2, pf_q)) begin
            pf_wr = pf_alt2;
        end else begin
            pf_wr = pf_keep;
        end
        // eeprom: disable may only fall, size may only grow in normal mode
        if (special_mode_in) begin
            ee_wr = pwdata_in[7:0] & `FEPR_EE_MASK;
        end else begin
            ee_wr = {ee_q[7] & pwdata_in[7], 5'h00,
                (pwdata_in[1:0] > ee_q[1:0]) ? pwdata_in[1:0] : ee_q[1:0]};
        end
    end

    // reset load sequence, then bus writes
    always_comb begin
        state_d = state_q;
        pf_d = pf_q;
        ee_d = ee_q;
        cfg_rd_req_out = (state_q != FEPR_READY);
        cfg_rd_addr_out = (state_q == FEPR_LD_EE) ? `FEPR_EE_CFG_ADDR : `FEPR_PF_CFG_ADDR;
        case (state_q)
            FEPR_LD_PF: begin
                if (cfg_rd_valid_in) begin
                    pf_d = cfg_rd_dbl_fault_in ? `FEPR_PF_FAULT_VAL : cfg_rd_data_in;
                    state_d = FEPR_LD_EE;
                end
            end
            FEPR_LD_EE: begin
                if (cfg_rd_valid_in) begin
                    ee_d = cfg_rd_dbl_fault_in ? `FEPR_EE_FAULT_VAL
                        : (cfg_rd_data_in & `FEPR_EE_MASK);
                    state_d = FEPR_READY;
                end
            end
            FEPR_READY: begin
                if (wr_pf) begin
                    pf_d = pf_wr;
                end
                if (wr_ee) begin
                    ee_d = ee_wr;
                end
            end
            default: state_d = FEPR_LD_PF;
        endcase
    end

    assign load_done_out = (state_q == FEPR_READY);

    // violation flag: a new refusal wins over a write-one clear
    always_comb begin
        viol_d = viol_q;
        if (wr_st && pwdata_in[`FEPR_VIOL_BIT]) begin
            viol_d = 1'b0;
        end
        if (chk_valid_in && refused) begin
            viol_d = 1'b1;
        end
    end

    // read data registered at the access phase
    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        ack_d = acc && !ack_q;
        if (!acc) begin
            err_d = 1'b0;
        end
        if (acc && !ack_q) begin
            err_d = (reg_sel(paddr_in) == 2'h0);
            case (reg_sel(paddr_in))
                2'h1: rdata_d = {27'h0, viol_q, 4'h0};
                2'h2: rdata_d = {24'h0, pf_q};
                2'h3: rdata_d = {24'h0, ee_q};
                default: rdata_d = 32'h0;
            endcase
        end
    end

    // one register stage for all state
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            state_q <= FEPR_LD_PF;
            pf_q <= `FEPR_PF_RST_VAL;
            ee_q <= `FEPR_EE_RST_VAL;
            viol_q <= 1'b0;
            rdata_q <= 32'h0;
            err_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            ack_q <= ack_d;
            state_q <= state_d;
            pf_q <= pf_d;
            ee_q <= ee_d;
            viol_q <= viol_d;
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    // checks on the decoded behaviour
    chk_pf_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (state_q == FEPR_LD_PF && cfg_rd_valid_in && !cfg_rd_dbl_fault_in)
        |=> (pf_q == $past(cfg_rd_data_in)) && (state_q == FEPR_LD_EE))
        else $error("pflash config not loaded");
    chk_pf_fault: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (state_q == FEPR_LD_PF && cfg_rd_valid_in && cfg_rd_dbl_fault_in)
        |=> pf_q == 8'h7F)
        else $error("pflash fault load not full protect");
    chk_ee_fault: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (state_q == FEPR_LD_EE && cfg_rd_valid_in && cfg_rd_dbl_fault_in)
        |=> ee_q == 8'h03 ##1 load_done_out)
        else $error("eeprom fault load not full protect");
    chk_viol_set: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (chk_valid_in && !chk_allowed_out) |=> viol_q && !cmd_launch_ok_out)
        else $error("refusal did not set violation");
    chk_viol_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_st && pwdata_in[4] && !(chk_valid_in && refused)) |=> !viol_q)
        else $error("write one did not clear violation");
    chk_viol_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (viol_q && !(wr_st && pwdata_in[4])) |=> viol_q)
        else $error("violation dropped without clear");
    chk_size_lock: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_pf && load_done_out && !pf_q[5]) |=> $stable(pf_q[4:3]))
        else $error("size changed while disable clear");
    chk_pf_full: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (chk_valid_in && !chk_eeprom_in && pf_q[7:5] == 3'b001) |-> !chk_allowed_out)
        else $error("full protect let access pass");
    chk_pf_erase: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (chk_valid_in && chk_blk_erase_in && !chk_eeprom_in && !(pf_q[7] && pf_q[5]))
        |-> !chk_allowed_out)
        else $error("pflash block erase passed");
    chk_ee_open: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (chk_valid_in && chk_eeprom_in && ee_q[7]) |-> chk_allowed_out)
        else $error("open eeprom refused access");
    chk_ee_dis_fall: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_ee && load_done_out && !special_mode_in && !ee_q[7]) |=> !ee_q[7] && ee_q[1:0]
        >= $past(ee_q[1:0]))
        else $error("normal eeprom write removed protection");
    chk_pf_grow: assert property (@(posedge clk_in) disable iff (!nrst_in)
        (wr_pf && load_done_out && !special_mode_in) |=> pf_covers(pf_q, $past(pf_q)))
        else $error("normal pflash write shrank protection");

endmodule : fepr_top
`default_nettype wire

// ### tb/fepr_cfg_model.sv
// flash side model that answers the reset-time configuration byte reads
`timescale 1ns/1ns
`default_nettype none
`include "fepr_regs.svh"
module fepr_cfg_model (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic rd_req_in,
    input wire logic [23:0] rd_addr_in,
    input wire logic [7:0] pf_byte_in,
    input wire logic [7:0] ee_byte_in,
    input wire logic fault_in,
    input wire logic [1:0] dly_in,
    output logic valid_out,
    output logic [7:0] data_out,
    output logic fault_out
);
    logic [1:0] cnt_q;
    // one answer per request, after dly_in idle cycles; data toggles when not valid
    always_ff @(posedge clk_in) begin
        if (!nrst_in) begin
            cnt_q <= 2'h0;
            valid_out <= 1'h0;
            data_out <= 8'h00;
            fault_out <= 1'h0;
        end else if (rd_req_in && !valid_out && cnt_q == dly_in) begin
            valid_out <= 1'h1;
            cnt_q <= 2'h0;
            fault_out <= fault_in;
            if (rd_addr_in == `FEPR_PF_CFG_ADDR) data_out <= pf_byte_in;
            else if (rd_addr_in == `FEPR_EE_CFG_ADDR) data_out <= ee_byte_in;
            else data_out <= ~data_out; // unknown address gets garbage
        end else begin
            valid_out <= 1'h0;
            fault_out <= 1'h0;
            data_out <= ~data_out; // no stale byte outside the pulse
            cnt_q <= (rd_req_in && !valid_out) ? cnt_q + 2'h1 : 2'h0;
        end
    end
endmodule : fepr_cfg_model
`default_nettype wire

// ### tb/fepr_top_tb.sv
// self-checking bench for the protection block
`timescale 1ns/1ns
`default_nettype none
`include "fepr_regs.svh"
module fepr_top_tb;
    // flags: special, eeprom, block erase, allowed
    typedef struct packed {
        logic [3:0] fl;
        logic [7:0] wd;
        logic [7:0] rd;
        logic [23:0] ad;
    } fepr_row_t;
    logic clk_in, nrst_in, special, psel, penable, pwrite, pready, pslverr, rd_req;
    logic vld, flt, fault, done, cvalid, cee, cblk, allowed, launch, al, lo;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, serr;
    logic [23:0] rd_addr, caddr;
    logic [7:0] vdata, pf_byte, ee_byte;
    logic [1:0] dly;
    int errors = 0;
    int total_checks = 0;
    fepr_row_t rows [22] = '{
        '{4'h0, 8'hDF, 8'hDF, 24'hFFE000}, '{4'h1, 8'hFF, 8'hDF, 24'hFFDFFF},
        '{4'h2, 8'hC7, 8'hDF, 24'hFFDFFF}, '{4'h5, 8'h81, 8'h81, 24'h100000},
        '{4'h4, 8'h00, 8'h01, 24'h10003F}, '{4'h5, 8'h80, 8'h01, 24'h100040},
        '{4'hF, 8'hFF, 8'h83, 24'h100000}, '{4'hC, 8'h02, 8'h02, 24'h10005F},
        '{4'hD, 8'h00, 8'h00, 24'h100020}, '{4'hE, 8'h00, 8'h00, 24'h100020},
        '{4'hC, 8'h03, 8'h03, 24'h10007F}, '{4'hD, 8'h03, 8'h03, 24'h100080},
        '{4'h8, 8'h20, 8'h38, 24'h000000}, '{4'h8, 8'h28, 8'h28, 24'h000000},
        '{4'hB, 8'hA8, 8'hA8, 24'hFFFFFF}, '{4'h8, 8'h88, 8'h88, 24'hFFF000},
        '{4'h9, 8'h88, 8'h88, 24'hFFEFFF}, '{4'h9, 8'h08, 8'h08, 24'hFFF000},
        '{4'h8, 8'h08, 8'h08, 24'hFFEFFF}, '{4'h8, 8'h20, 8'h28, 24'hFFFFFF},
        '{4'h9, 8'h80, 8'h80, 24'hFFF7FF}, '{4'h8, 8'h80, 8'h80, 24'hFFF800}};

    always #10 clk_in = ~clk_in;

    fepr_top uut (.clk_in(clk_in), .nrst_in(nrst_in), .special_mode_in(special),
        .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(pslverr),
        .cfg_rd_req_out(rd_req), .cfg_rd_addr_out(rd_addr), .cfg_rd_valid_in(vld),
        .cfg_rd_data_in(vdata), .cfg_rd_dbl_fault_in(flt), .load_done_out(done),
        .chk_valid_in(cvalid), .chk_addr_in(caddr), .chk_eeprom_in(cee),
        .chk_blk_erase_in(cblk), .chk_allowed_out(allowed), .cmd_launch_ok_out(launch));

    fepr_cfg_model model (.clk_in(clk_in), .nrst_in(nrst_in), .rd_req_in(rd_req),
        .rd_addr_in(rd_addr), .pf_byte_in(pf_byte), .ee_byte_in(ee_byte), .fault_in(fault),
        .dly_in(dly), .valid_out(vld), .data_out(vdata), .fault_out(flt));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // read data and error are taken at the edge where pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        @(posedge clk_in);
        psel <= 1'h1; penable <= 1'h0; pwrite <= wr; paddr <= a; pwdata <= wd;
        @(posedge clk_in);
        penable <= 1'h1;
        n = 0;
        do begin
            @(posedge clk_in);
            n++;
        end while (pready !== 1'h1 && n < 50);
        rdat = prdata;
        serr = {31'h0, pslverr};
        if (n >= 50) errors++;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask : apb

    task automatic offer(input logic [23:0] a, input logic e, input logic b);
        @(posedge clk_in);
        cvalid <= 1'h1; caddr <= a; cee <= e; cblk <= b;
        #1 al = allowed;
        @(posedge clk_in);
        cvalid <= 1'h0;
        #1 lo = launch;
    endtask : offer

    task automatic wait_load;
        for (int n = 0; n < 60 && done !== 1'h1; n++) @(posedge clk_in);
    endtask : wait_load

    task automatic results;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    // watchdog far beyond the expected several hundred cycles
    initial begin
        repeat (20000) @(posedge clk_in);
        errors++;
        results();
    end

    initial begin
        clk_in = 1'h0; nrst_in = 1'h0; special = 1'h0; psel = 1'h0; penable = 1'h0;
        pwrite = 1'h0; paddr = 12'h000; pwdata = 32'h0; cvalid = 1'h0; caddr = 24'h0;
        cee = 1'h0; cblk = 1'h0; fault = 1'h0; dly = 2'h0;
        pf_byte = 8'hFF; // reserved bits kept erased
        ee_byte = 8'h80;
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'h1;
        wait_load();
        apb(1'h0, `FEPR_PF_OFS, 32'h0); check(rdat, 32'hFF);
        apb(1'h0, `FEPR_EE_OFS, 32'h0); check(rdat, 32'h80);
        // table rows: write, read back, offer a target, then the sticky flag
        foreach (rows[i]) begin
            @(posedge clk_in);
            special <= rows[i].fl[3];
            apb(1'h1, rows[i].fl[2] ? `FEPR_EE_OFS : `FEPR_PF_OFS, {24'h0, rows[i].wd});
            apb(1'h0, rows[i].fl[2] ? `FEPR_EE_OFS : `FEPR_PF_OFS, 32'h0);
            check(rdat, {24'h0, rows[i].rd});
            offer(rows[i].ad, rows[i].fl[2], rows[i].fl[1]);
            check(al, rows[i].fl[0]);
            check(lo, rows[i].fl[0]);
            apb(1'h1, `FEPR_STATUS_OFS, 32'h0);
            apb(1'h0, `FEPR_STATUS_OFS, 32'h0);
            check(rdat & 32'h10, {27'h0, ~rows[i].fl[0], 4'h0});
            apb(1'h1, `FEPR_STATUS_OFS, 32'h10);
            apb(1'h0, `FEPR_STATUS_OFS, 32'h0); check(rdat & 32'h10, 32'h0);
        end
        apb(1'h0, 12'h010, 32'h0); check(serr, 32'h1); check(rdat, 32'h0);
        // second reset with faulty bytes and a slow flash; write during load is lost
        @(posedge clk_in);
        fault <= 1'h1; dly <= 2'h3; special <= 1'h1; nrst_in <= 1'h0;
        repeat (12) @(posedge clk_in);
        nrst_in <= 1'h1;
        apb(1'h1, `FEPR_PF_OFS, 32'hFF);
        wait_load();
        apb(1'h0, `FEPR_PF_OFS, 32'h0); check(rdat, 32'h7F);
        apb(1'h0, `FEPR_EE_OFS, 32'h0); check(rdat, 32'h03);
        offer(24'h000000, 1'h0, 1'h0); check(al, 1'h0);
        offer(24'h10007F, 1'h1, 1'h0); check(al, 1'h0);
        results();
    end
endmodule : fepr_top_tb
`default_nettype wire
